// *** rtl/dihg_guard.sv ***
`timescale 1ns/100ps
// Contract
// - halfword and word unsigned divides are the only hazard-arming instructions.
// - hazard considered only inside a service routine with nesting re-enabled.
// - the instruction right after the divide must be second-class.
// - divide run from ram makes any successor second-class.
// - a request raised in the divide's last two cycles is late.
// - a second request must be held pending before the window.
// - branch between running and late routines must behave correctly.
// - acceptance uses four priority levels, 0 to 3.
// - only the listed running/suspended/late level combinations are affected.
// - successors taking two or more cycles are second-class.
// - successors reading code flash or its mirror are second-class.
// - status-word writes, mask/unmask, returns and skips are second-class.
// - writes to request, mask or priority flag registers are second-class.
module dihg_guard
   import dihg_pkg::*;
#(
   parameter int HALF_CYC = DIHG_HALF_DIV_CYC,
   parameter int WORD_CYC = DIHG_WORD_DIV_CYC
) (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // execute pipeline
   input  wire logic                  instr_start,
   input  wire logic                  instr_done,
   input  wire logic                  unsigned_halfword_divide,
   input  wire logic                  unsigned_word_divide,
   input  wire logic                  instr_from_ram,
   input  wire logic [DIHG_CYC_W-1:0] instr_cycles,
   input  wire logic                  instr_flash_read,
   input  wire logic                  instr_suspends,
   input  wire logic                  instr_irq_reg_write,
   // interrupt priority controller
   input  wire logic                  isr_active,
   input  wire logic                  nest_enabled,
   input  wire logic [DIHG_LVL_W-1:0] run_level,
   input  wire logic                  pend_valid,
   input  wire logic [DIHG_LVL_W-1:0] pend_level,
   input  wire logic                  req_raise,
   input  wire logic [DIHG_LVL_W-1:0] req_level,
   // results
   output logic                       accept_hold,
   output logic                       release_pulse,
   output logic [DIHG_LVL_W-1:0]      late_level,
   output logic                       hazard_pulse,
   output dihg_why_t                  hazard_why,
   output logic                       div_busy
);
   dihg_cls_if cls ();

   dihg_state_t           state;
   logic [DIHG_CNT_W-1:0] cyc_cnt;
   logic [DIHG_CNT_W-1:0] div_len;
   logic                  div_ram;
   logic                  div_nested;
   logic                  late_seen;
   logic                  late_combo;
   logic                  is_div;
   logic                  window;

   // levels run 0..3 with 0 most urgent
   function automatic logic combo_hit(input logic [DIHG_LVL_W-1:0] a,
                                      input logic [DIHG_LVL_W-1:0] b,
                                      input logic [DIHG_LVL_W-1:0] c);
      logic hit;
      hit = 1'b0;
      case (a)
         DIHG_LVL0, DIHG_LVL1: hit = (b >= DIHG_LVL1) && (c == DIHG_LVL0);
         DIHG_LVL2:            hit = (b >= DIHG_LVL2) && (c <= DIHG_LVL1);
         default:              hit = 1'b0;
      endcase
      return hit;
   endfunction

   function automatic logic last_two(input logic [DIHG_CNT_W-1:0] cnt,
                                     input logic [DIHG_CNT_W-1:0] len);
      return (cnt + DIHG_CNT_W'(DIHG_WINDOW_SPAN) > len) && (cnt <= len);
   endfunction

   assign is_div = unsigned_halfword_divide | unsigned_word_divide;
   assign window = (state == DIHG_DIV) && last_two(cyc_cnt, div_len);

   assign cls.succ_cycles        = instr_cycles;
   assign cls.succ_flash_read    = instr_flash_read;
   assign cls.succ_suspends      = instr_suspends;
   assign cls.succ_irq_reg_write = instr_irq_reg_write;
   assign cls.div_from_ram       = div_ram;

   dihg_classify u_cls (
      .cls (cls)
   );

   // sequencing of the divide and its successor
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= DIHG_IDLE;
      end else if (ce) begin
         case (state)
            DIHG_IDLE: begin
               if (instr_start && is_div) begin
                  state <= DIHG_DIV;
               end
            end
            DIHG_DIV: begin
               if (cyc_cnt == div_len) begin
                  state <= DIHG_GAP;
               end
            end
            DIHG_GAP: begin
               if (instr_start) begin
                  state <= DIHG_SUCC;
               end
            end
            DIHG_SUCC: begin
               if (instr_done) begin
                  state <= DIHG_IDLE;
               end
            end
            default: state <= DIHG_IDLE;
         endcase
      end
   end

   // divide cycle count, cycle 1 is the start cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         cyc_cnt <= 5'h00;
         div_len <= 5'h00;
      end else if (ce) begin
         if (state == DIHG_IDLE && instr_start && is_div) begin
            cyc_cnt <= 5'h02;
            div_len <= unsigned_word_divide ? DIHG_CNT_W'(WORD_CYC)
                                            : DIHG_CNT_W'(HALF_CYC);
         end else if (state == DIHG_DIV) begin
            cyc_cnt <= cyc_cnt + 5'h01;
         end
      end
   end

   // context captured when the divide starts
   always_ff @(posedge mclk) begin
      if (rst) begin
         div_ram    <= 1'b0;
         div_nested <= 1'b0;
      end else if (ce) begin
         if (state == DIHG_IDLE && instr_start && is_div) begin
            div_ram    <= instr_from_ram;
            div_nested <= isr_active && nest_enabled;
         end
      end
   end

   // late request capture; start cycle counts as cycle 1
   always_ff @(posedge mclk) begin
      if (rst) begin
         late_seen  <= 1'b0;
         late_combo <= 1'b0;
         late_level <= 2'h0;
      end else if (ce) begin
         if (state == DIHG_IDLE) begin
            late_seen  <= 1'b0;
            late_combo <= 1'b0;
         end else if (window && req_raise && !late_seen) begin
            late_seen  <= 1'b1;
            late_level <= req_level;
            // suspended request must already be waiting
            late_combo <= div_nested && pend_valid &&
                          combo_hit(run_level, pend_level, req_level);
         end
      end
   end

   // hazard report when the successor is classified
   always_ff @(posedge mclk) begin
      if (rst) begin
         hazard_pulse <= 1'b0;
         hazard_why   <= DIHG_WHY_NONE;
      end else if (ce) begin
         hazard_pulse <= 1'b0;
         if (state == DIHG_GAP && instr_start && late_seen && late_combo &&
             cls.second_class) begin
            hazard_pulse <= 1'b1;
            hazard_why   <= cls.why;
         end
      end
   end

   // release of the deferred request after the successor ends
   always_ff @(posedge mclk) begin
      if (rst) begin
         release_pulse <= 1'b0;
      end else if (ce) begin
         release_pulse <= (state == DIHG_SUCC) && instr_done && late_seen;
      end
   end

   // holding every late request, not just flagged ones, keeps the fix simple
   // and costs at most one instruction of latency
   always_comb begin
      accept_hold = 1'b0;
      if (late_seen && (state == DIHG_DIV || state == DIHG_GAP || state == DIHG_SUCC)) begin
         accept_hold = 1'b1;
      end else if (window && req_raise) begin
         accept_hold = 1'b1;
      end
   end

   assign div_busy = (state == DIHG_DIV);
endmodule

// *** rtl/dihg_pkg.sv ***
package dihg_pkg;
   // priority levels, 0 is the most urgent
   localparam int          DIHG_LVL_W          = 2;
   localparam int          DIHG_CNT_W          = 5;
   localparam int          DIHG_CYC_W          = 4;
   localparam int          DIHG_HALF_DIV_CYC   = 9;
   localparam int          DIHG_WORD_DIV_CYC   = 17;
   localparam int          DIHG_WINDOW_SPAN    = 2;
   localparam int          DIHG_MULTI_CYC_MIN  = 2;
   localparam logic [1:0]  DIHG_LVL0           = 2'h0;
   localparam logic [1:0]  DIHG_LVL1           = 2'h1;
   localparam logic [1:0]  DIHG_LVL2           = 2'h2;
   localparam logic [1:0]  DIHG_LVL3           = 2'h3;

   typedef enum logic [2:0] {
      DIHG_WHY_NONE,
      DIHG_WHY_RAM,
      DIHG_WHY_MULTI,
      DIHG_WHY_FLASH,
      DIHG_WHY_SUSPEND,
      DIHG_WHY_IRQ_REG
   } dihg_why_t;

   typedef enum logic [1:0] {
      DIHG_IDLE,
      DIHG_DIV,
      DIHG_GAP,
      DIHG_SUCC
   } dihg_state_t;
endpackage

// *** rtl/dihg_cls_if.sv ***
`timescale 1ns/100ps
interface dihg_cls_if;
   import dihg_pkg::*;
   logic [DIHG_CYC_W-1:0] succ_cycles;
   logic                  succ_flash_read;
   logic                  succ_suspends;
   logic                  succ_irq_reg_write;
   logic                  div_from_ram;
   logic                  second_class;
   dihg_why_t             why;

   modport classifier (
      input  succ_cycles, succ_flash_read, succ_suspends, succ_irq_reg_write, div_from_ram,
      output second_class, why
   );
   modport user (
      output succ_cycles, succ_flash_read, succ_suspends, succ_irq_reg_write, div_from_ram,
      input  second_class, why
   );
endinterface

// *** rtl/dihg_classify.sv ***
`timescale 1ns/100ps
module dihg_classify
   import dihg_pkg::*;
(
   dihg_cls_if.classifier cls
);
   // first matching cause is reported
   always_comb begin
      cls.second_class = 1'b1;
      if (cls.div_from_ram) begin
         cls.why = DIHG_WHY_RAM;
      end else if (cls.succ_cycles >= DIHG_CYC_W'(DIHG_MULTI_CYC_MIN)) begin
         cls.why = DIHG_WHY_MULTI;
      end else if (cls.succ_flash_read) begin
         cls.why = DIHG_WHY_FLASH;
      end else if (cls.succ_suspends) begin
         cls.why = DIHG_WHY_SUSPEND;
      end else if (cls.succ_irq_reg_write) begin
         cls.why = DIHG_WHY_IRQ_REG;
      end else begin
         cls.why          = DIHG_WHY_NONE;
         cls.second_class = 1'b0;
      end
   end
endmodule

// *** tb/dihg_irq_model.sv ***
`timescale 1ns/100ps
// interrupt controller side: raises one request dly cycles after fire
module dihg_irq_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       fire,
   input  wire logic [4:0] dly,
   input  wire logic [1:0] lvl,
   output logic            req_raise,
   output logic [1:0]      req_level
);
   logic [4:0] cnt;
   always_ff @(posedge mclk) begin
      if (rst) cnt <= 5'h0;
      else if (fire) cnt <= 5'h1;
      else if (cnt != 5'h0 && cnt != 5'h1f) cnt <= cnt + 5'h1;
      else cnt <= 5'h0;
   end
   // idle level line shows the inverse, so a stale value never passes
   always @(negedge mclk) begin
      req_raise <= cnt == dly && dly != 5'h0;
      req_level <= (cnt == dly) ? lvl : ~lvl;
   end
endmodule

// *** tb/dihg_guard_asserts.sv ***
`timescale 1ns/100ps
module dihg_guard_asserts
   import dihg_pkg::*;
#(
   parameter int HALF_CYC = 9,
   parameter int WORD_CYC = 17
) (
   // clock and reset
   input wire logic       mclk, rst,
   // pipeline and controller
   input wire logic       instr_start, instr_done, req_raise, isr_active,
   input wire logic       unsigned_halfword_divide, unsigned_word_divide,
   input wire logic [1:0] pend_level,
   // results
   input wire logic       accept_hold, release_pulse, hazard_pulse, div_busy,
   input wire logic [1:0] late_level,
   input wire dihg_why_t  hazard_why
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_half; div_busy [*8] ##1 !div_busy; endsequence
   sequence s_word; div_busy [*8] ##1 div_busy [*8] ##1 !div_busy; endsequence
   chk_half_len: assert property ($rose(div_busy) && $past(unsigned_halfword_divide) |-> s_half)
      else $error("halfword divide busy length wrong");
   chk_word_len: assert property ($rose(div_busy) && $past(unsigned_word_divide) |-> s_word)
      else $error("word divide busy length wrong");
   chk_hazard_single: assert property (hazard_pulse |=> !hazard_pulse)
      else $error("hazard pulse too long");
   chk_hazard_succ: assert property (hazard_pulse |-> $past(instr_start))
      else $error("hazard without successor");
   chk_hazard_combo: assert property (hazard_pulse |-> late_level <= 2'h1 && pend_level != 2'h0
      && isr_active)
      else $error("hazard on unaffected levels");
   chk_hazard_held: assert property (hazard_pulse |-> accept_hold && hazard_why != DIHG_WHY_NONE)
      else $error("hazard not held or no cause");
   chk_why_holds: assert property (!hazard_pulse |-> hazard_why == $past(hazard_why))
      else $error("cause changed without hazard");
   chk_hold_start: assert property ($rose(accept_hold) |-> req_raise && div_busy)
      else $error("hold raised outside window");
   chk_hold_end: assert property ($fell(accept_hold) |-> release_pulse && $past(instr_done))
      else $error("hold dropped without release");
   chk_release_one: assert property (release_pulse |=> !release_pulse)
      else $error("release pulse too long");
endmodule
bind dihg_guard dihg_guard_asserts #(.HALF_CYC(HALF_CYC), .WORD_CYC(WORD_CYC)) u_chk (
   .mclk, .rst, .instr_start, .instr_done, .req_raise, .isr_active, .unsigned_halfword_divide,
   .unsigned_word_divide, .pend_level, .accept_hold, .release_pulse, .hazard_pulse, .div_busy,
   .late_level, .hazard_why);

// *** tb/test_divide_interrupt_hazard_guard.sv ***
`timescale 1ns/100ps
module test_divide_interrupt_hazard_guard;
   import dihg_pkg::*;
   logic       mclk = 1'b0, rst = 1'b1, ce = 1'b1, instr_start = 1'b0, instr_done = 1'b0;
   logic       unsigned_halfword_divide = 1'b0, unsigned_word_divide = 1'b0, fire = 1'b0;
   logic       instr_from_ram = 1'b0, instr_flash_read = 1'b0, instr_suspends = 1'b0;
   logic       instr_irq_reg_write = 1'b0, isr_active = 1'b1, nest_enabled = 1'b1;
   logic       pend_valid = 1'b1, req_raise, accept_hold, release_pulse, hazard_pulse, div_busy;
   logic [3:0] instr_cycles = 4'h1;
   logic [1:0] run_level = 2'h0, pend_level = 2'h1, req_level, late_level, fire_lvl = 2'h0;
   logic [4:0] fire_dly = 5'h0;
   dihg_why_t  hazard_why;
   int         fail_count = 0, n_compared = 0, cycles = 0;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
   dihg_guard dut (.mclk, .rst, .ce, .instr_start, .instr_done, .unsigned_halfword_divide,
      .unsigned_word_divide, .instr_from_ram, .instr_cycles, .instr_flash_read, .instr_suspends,
      .instr_irq_reg_write, .isr_active, .nest_enabled, .run_level, .pend_valid, .pend_level,
      .req_raise, .req_level, .accept_hold, .release_pulse, .late_level, .hazard_pulse,
      .hazard_why, .div_busy);
   dihg_irq_model irq (.mclk, .rst, .fire, .dly(fire_dly), .lvl(fire_lvl), .req_raise,
      .req_level);
   always #5 mclk = ~mclk;
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // whole run needs about 970 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         tally_and_finish;
      end
   end
   // divide, late request dly cycles after start, then a successor
   task automatic div_run(input logic w, ram, input logic [3:0] cyc, input logic fl, su, iw,
         input int dly, input logic [1:0] cl, input logic exph, input dihg_why_t expw);
      int   len;
      logic late;
      len = w ? DIHG_WORD_DIV_CYC : DIHG_HALF_DIV_CYC;
      late = dly == len - 2 || dly == len - 1;
      @(negedge mclk);
      {instr_start, unsigned_word_divide, unsigned_halfword_divide} = {1'b1, w, !w};
      {instr_from_ram, fire, fire_dly, fire_lvl} = {ram, 1'b1, 5'(dly), cl};
      @(negedge mclk);
      {instr_start, unsigned_word_divide, unsigned_halfword_divide, instr_from_ram} = 4'h0;
      fire = 1'b0;
      repeat (len - 1) @(negedge mclk);
      `CHK("hold in gap", late, accept_hold)
      {instr_start, instr_flash_read, instr_suspends, instr_irq_reg_write} = {1'b1, fl, su, iw};
      instr_cycles = cyc;
      @(negedge mclk);
      `CHK("hazard", exph, hazard_pulse)
      if (exph) `CHK("cause", expw, hazard_why)
      {instr_start, instr_done} = 2'h1;
      @(negedge mclk);
      instr_done = 1'b0;
      `CHK("release", late, release_pulse)
      `CHK("hold after", 1'b0, accept_hold)
      if (late) `CHK("late level", cl, late_level)
   endtask
   task automatic t_ram_half;
      div_run('0, '1, 4'h1, '0, '0, '0, 7, 2'h0, '1, DIHG_WHY_RAM);
      div_run('0, '0, 4'h1, '0, '0, '0, 8, 2'h0, '0, DIHG_WHY_NONE);
   endtask
   task automatic t_classes;
      div_run('1, '0, 4'h2, '0, '0, '0, 16, 2'h0, '1, DIHG_WHY_MULTI);
      div_run('1, '0, 4'h1, '1, '0, '0, 15, 2'h0, '1, DIHG_WHY_FLASH);
      div_run('1, '0, 4'h1, '0, '1, '0, 16, 2'h0, '1, DIHG_WHY_SUSPEND);
      div_run('1, '0, 4'h1, '0, '0, '1, 15, 2'h0, '1, DIHG_WHY_IRQ_REG);
      div_run('1, '1, 4'h3, '1, '1, '1, 15, 2'h0, '1, DIHG_WHY_RAM);
   endtask
   task automatic t_combos;
      logic e;
      for (int a = 0; a < 4; a++)
         for (int b = 0; b < 4; b++)
            for (int c = 0; c < 4; c++) begin
               {run_level, pend_level} = {2'(a), 2'(b)};
               e = (a <= 1 && b >= 1 && c == 0) || (a == 2 && b >= 2 && c <= 1);
               div_run('0, '0, 4'h2, '0, '0, '0, 8, 2'(c), e, DIHG_WHY_MULTI);
            end
   endtask
   task automatic t_gates;
      {run_level, pend_level, nest_enabled} = {2'h0, 2'h1, 1'b0};
      div_run('0, '0, 4'h2, '0, '0, '0, 7, 2'h0, '0, DIHG_WHY_NONE);
      {nest_enabled, isr_active} = 2'h2;
      div_run('0, '0, 4'h2, '0, '0, '0, 7, 2'h0, '0, DIHG_WHY_NONE);
      {isr_active, pend_valid} = 2'h2;
      div_run('0, '0, 4'h2, '0, '0, '0, 7, 2'h0, '0, DIHG_WHY_NONE);
      pend_valid = 1'b1;
      div_run('0, '0, 4'h2, '0, '0, '0, 6, 2'h0, '0, DIHG_WHY_NONE);
      // masked around the divide: no request is ever raised
      div_run('0, '0, 4'h2, '0, '0, '0, 0, 2'h0, '0, DIHG_WHY_NONE);
   endtask
   // clock enable low must swallow a divide start
   task automatic t_freeze;
      @(negedge mclk);
      {ce, instr_start, unsigned_word_divide} = 3'h3;
      repeat (3) @(negedge mclk);
      {ce, instr_start, unsigned_word_divide} = 3'h4;
      @(negedge mclk);
      `CHK("frozen busy", 1'b0, div_busy)
   endtask
   initial begin
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      `CHK("reset outs", 4'h0, {accept_hold, release_pulse, hazard_pulse, div_busy})
      `CHK("reset why", DIHG_WHY_NONE, hazard_why)
      t_freeze;
      t_ram_half;
      t_classes;
      t_combos;
      t_gates;
      tally_and_finish;
   end
endmodule
